/* File: core/instruction_cache_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "icache_ctl_cfg.svh"
// Summary of operation
// - enable bit gates hits and allocation, contents kept
// - option clear: no inhibited accesses buffered
// - option set: buffer only normal inhibited reads
// - buffer loaded by burst, hits skip bus
// - buffer valid until invalidate, burst, fill, option clear
// - writes bypass buffer, buffer stays stale
// - push invalidates line when disable clear
// - push leaves line valid when disable set
// - lowest invalid way, else round-robin mod 4
// - half-lock: ways 2,3, round-robin mod 2
// - half-lock never allocates ways 0,1
// - half-lock change acts immediately
// - default mode picks unmatched access mode
// - invalidate-all write starts sequential sweep
// - sweep stalls accesses, bit self-clears
// - reset leaves tags and valid bits alone
// - register written by control-register move
// - reset clears whole control register
module instruction_cache_control (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ctl_wr,
	input wire logic [31:0] i_ctl_wdata,
	output logic [31:0] o_ctl_rdata,
	input wire logic i_fetch_req,
	input wire logic [31:0] i_fetch_addr,
	input wire logic [1:0] i_transfer_type,
	input wire logic i_region_hit,
	input wire logic i_region_inhibit,
	output logic o_fetch_done,
	output logic o_cache_hit,
	output logic o_fb_hit,
	output icache_ctl_pkg::way_t o_hit_way,
	output logic o_fill_req,
	output logic o_fill_burst,
	output logic o_fill_to_buffer,
	output icache_ctl_pkg::way_t o_fill_way,
	output logic [31:0] o_fill_addr,
	input wire logic i_store_req,
	input wire logic [31:0] i_store_addr,
	output logic o_bus_write,
	output logic o_store_hit,
	output icache_ctl_pkg::way_t o_store_way,
	input wire logic i_push_req,
	input wire icache_ctl_pkg::set_idx_t i_push_set,
	input wire icache_ctl_pkg::way_t i_push_way,
	output logic o_push_done,
	output logic o_push_valid,
	output logic [31:0] o_push_addr,
	output logic o_stall
);
	import icache_ctl_pkg::*;

	function automatic logic [3:0] tag_match(input logic [3:0][19:0] tags,
		input logic [3:0] vld, input tag_t t);
		logic [3:0] m;
		m = 4'h0;
		for (int w = 0; w < `IC_WAYS; w++) begin
			m[w] = vld[w] && (tags[w] == t);
		end
		return m;
	endfunction

	function automatic way_t way_enc(input logic [3:0] m);
		way_t w;
		w = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
		return w;
	endfunction

	// cache arrays: no reset port, so reset never touches them
	logic [3:0][19:0] tag_mem [0:`IC_SETS-1];
	logic [3:0] valid_mem [0:`IC_SETS-1];

	logic [31:0] cc_reg;
	logic [31:0] cc_next;
	ctl_state_t state_reg;
	ctl_state_t state_next;
	set_idx_t sweep_reg;
	set_idx_t sweep_next;
	logic fb_valid_reg;
	logic fb_valid_next;
	line_addr_t fb_line_reg;
	line_addr_t fb_line_next;

	alloc_if au();

	way_alloc u_alloc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.a(au.chooser)
	);

	wire logic icache_en = cc_reg[`CC_ICACHE_EN_BIT];
	wire logic inhibited_fill_buffer_en = cc_reg[`CC_IFB_EN_BIT];
	wire logic push_invalidate_disable = cc_reg[`CC_PUSH_INV_DIS_BIT];
	wire logic icache_half_lock = cc_reg[`CC_HALF_LOCK_BIT];
	wire logic icache_default_mode = cc_reg[`CC_DEF_MODE_BIT];
	wire logic icache_invalidate_all = cc_reg[`CC_INV_ALL_BIT];

	wire logic idle = (state_reg == st_idle);
	wire logic inv_start = i_ctl_wr && i_ctl_wdata[`CC_INV_ALL_BIT];
	wire logic sweep_end = (state_reg == st_sweep) && (sweep_reg == `IC_LAST_SET);

	// fetch decode
	wire set_idx_t f_set = i_fetch_addr[`IC_INDEX_MSB:`IC_INDEX_LSB];
	wire tag_t f_tag = i_fetch_addr[31:`IC_TAG_LSB];
	wire line_addr_t f_line = i_fetch_addr[31:`IC_INDEX_LSB];
	wire logic take_fetch = i_fetch_req && idle;
	// region registers win, otherwise the default mode bit decides
	wire logic eff_inhibit = i_region_hit ? i_region_inhibit : icache_default_mode;
	// a disabled cache neither hits nor allocates
	wire logic cacheable = icache_en && !eff_inhibit;
	wire logic [3:0] f_match = tag_match(tag_mem[f_set], valid_mem[f_set], f_tag);
	wire logic f_hit = cacheable && (|f_match);
	wire logic alloc = take_fetch && cacheable && !(|f_match);
	// buffer only for normal reads of inhibited regions with option set
	wire logic fb_usable = inhibited_fill_buffer_en && eff_inhibit &&
		(i_transfer_type == `TT_NORMAL);
	wire logic fb_match = fb_usable && fb_valid_reg && (fb_line_reg == f_line);
	wire logic fb_burst = take_fetch && fb_usable && !fb_match;
	wire logic single_rd = take_fetch && !f_hit && !fb_match && !alloc && !fb_burst;

	// store decode
	wire set_idx_t s_set = i_store_addr[`IC_INDEX_MSB:`IC_INDEX_LSB];
	wire tag_t s_tag = i_store_addr[31:`IC_TAG_LSB];
	wire logic take_store = i_store_req && idle;
	wire logic [3:0] s_match = tag_match(tag_mem[s_set], valid_mem[s_set], s_tag);

	// push decode
	wire logic take_push = i_push_req && idle;
	wire logic [3:0][19:0] p_tags = tag_mem[i_push_set];
	wire logic [3:0] p_valid = valid_mem[i_push_set];
	wire logic push_clear = take_push && !push_invalidate_disable;

	assign au.set_valid = valid_mem[f_set];
	assign au.half_lock = icache_half_lock;
	assign au.take = alloc;

	always_comb begin
		cc_next = cc_reg;
		if (i_ctl_wr) begin
			// unimplemented and reserved bits are dropped and read as zero
			cc_next = i_ctl_wdata & `CC_WRITE_MASK;
		end
		// a new request to invalidate beats completion of the old sweep
		if (inv_start) begin
			cc_next[`CC_INV_ALL_BIT] = 1'b1;
		end else if (sweep_end) begin
			cc_next[`CC_INV_ALL_BIT] = 1'b0;
		end else if (i_ctl_wr) begin
			cc_next[`CC_INV_ALL_BIT] = icache_invalidate_all;
		end
	end

	always_comb begin
		state_next = state_reg;
		sweep_next = sweep_reg;
		case (state_reg)
			st_idle: begin
				if (inv_start) begin
					state_next = st_sweep;
					sweep_next = 8'h00;
				end
			end
			st_sweep: begin
				if (inv_start) begin
					sweep_next = 8'h00;
				end else if (sweep_end) begin
					state_next = st_idle;
				end else begin
					sweep_next = sweep_reg + 8'h01;
				end
			end
			default: begin
				state_next = st_idle;
			end
		endcase
	end

	always_comb begin
		fb_valid_next = fb_valid_reg;
		fb_line_next = fb_line_reg;
		// stores never touch the buffer, so it may serve stale words
		if (fb_burst) begin
			fb_valid_next = 1'b1;
			fb_line_next = f_line;
		end else if (inv_start || alloc || !inhibited_fill_buffer_en) begin
			fb_valid_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cc_reg <= `CC_RESET;
			o_ctl_rdata <= `CC_RESET;
			state_reg <= st_idle;
			sweep_reg <= 8'h00;
			o_stall <= 1'b0;
			fb_valid_reg <= 1'b0;
			fb_line_reg <= 28'h000_0000;
		end else begin
			cc_reg <= cc_next;
			o_ctl_rdata <= cc_next;
			state_reg <= state_next;
			sweep_reg <= sweep_next;
			o_stall <= (state_next == st_sweep);
			fb_valid_reg <= fb_valid_next;
			fb_line_reg <= fb_line_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fetch_done <= 1'b0;
			o_cache_hit <= 1'b0;
			o_fb_hit <= 1'b0;
			o_hit_way <= 2'h0;
			o_fill_req <= 1'b0;
			o_fill_burst <= 1'b0;
			o_fill_to_buffer <= 1'b0;
			o_fill_way <= 2'h0;
			o_fill_addr <= 32'h0000_0000;
		end else begin
			o_fetch_done <= take_fetch;
			o_cache_hit <= take_fetch && f_hit;
			o_fb_hit <= take_fetch && fb_match;
			o_hit_way <= way_enc(f_match);
			o_fill_req <= alloc || fb_burst || single_rd;
			o_fill_burst <= alloc || fb_burst;
			o_fill_to_buffer <= fb_burst;
			o_fill_way <= au.way;
			o_fill_addr <= (alloc || fb_burst) ? {f_line, 4'h0} : i_fetch_addr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_write <= 1'b0;
			o_store_hit <= 1'b0;
			o_store_way <= 2'h0;
			o_push_done <= 1'b0;
			o_push_valid <= 1'b0;
			o_push_addr <= 32'h0000_0000;
		end else begin
			o_bus_write <= take_store;
			// write hits update any way, locked ones included
			o_store_hit <= take_store && icache_en && (|s_match);
			o_store_way <= way_enc(s_match);
			o_push_done <= take_push;
			o_push_valid <= take_push && p_valid[i_push_way];
			o_push_addr <= {p_tags[i_push_way], i_push_set, 4'h0};
		end
	end

	// no reset branch: tags and valid bits survive reset
	always_ff @(posedge i_clk) begin
		if (state_reg == st_sweep) begin
			valid_mem[sweep_reg] <= 4'h0;
		end else begin
			if (alloc) begin
				tag_mem[f_set][au.way] <= f_tag;
				valid_mem[f_set][au.way] <= 1'b1;
			end
			if (push_clear) begin
				valid_mem[i_push_set][i_push_way] <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: inc/icache_ctl_cfg.svh */
`ifndef ICACHE_CTL_CFG_SVH
`define ICACHE_CTL_CFG_SVH

// cache control register bit positions
`define CC_ICACHE_EN_BIT 15
`define CC_IFB_EN_BIT 13
`define CC_PUSH_INV_DIS_BIT 12
`define CC_HALF_LOCK_BIT 11
`define CC_DEF_MODE_BIT 10
`define CC_INV_ALL_BIT 8

// reset value and implemented-bit mask of the cache control register
`define CC_RESET 32'h0000_0000
`define CC_WRITE_MASK 32'h0000_BD00

// geometry: 256 sets of 4 ways, 16-byte lines
`define IC_SETS 256
`define IC_WAYS 4
`define IC_INDEX_LSB 4
`define IC_INDEX_MSB 11
`define IC_TAG_LSB 12
`define IC_LAST_SET 8'hFF

// transfer type of a normal instruction read
`define TT_NORMAL 2'h0

`endif

/* File: inc/icache_ctl_pkg.sv */
package icache_ctl_pkg;
	typedef logic [7:0] set_idx_t;
	typedef logic [1:0] way_t;
	typedef logic [19:0] tag_t;
	typedef logic [27:0] line_addr_t;
	typedef enum logic {st_idle, st_sweep} ctl_state_t;
endpackage

/* File: inc/alloc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface alloc_if;
	logic [3:0] set_valid;
	logic half_lock;
	logic take;
	logic [1:0] way;
	modport chooser(input set_valid, input half_lock, input take, output way);
	modport user(output set_valid, output half_lock, output take, input way);
endinterface
`default_nettype wire

/* File: core/way_alloc.sv */
`timescale 1ns/10ps
`default_nettype none
module way_alloc (
	input wire logic i_clk,
	input wire logic i_rst,
	alloc_if.chooser a
);
	logic [1:0] rr_reg;
	logic [1:0] rr_next;
	logic [1:0] full_way;
	logic [1:0] half_way;
	logic all_valid;
	logic advance;

	// lowest invalid way, else the round-robin way
	assign full_way = !a.set_valid[0] ? 2'h0 :
		!a.set_valid[1] ? 2'h1 :
		!a.set_valid[2] ? 2'h2 :
		!a.set_valid[3] ? 2'h3 : rr_reg;
	// only ways 2 and 3; high counter bit picks when both valid
	assign half_way = !a.set_valid[2] ? 2'h2 :
		!a.set_valid[3] ? 2'h3 :
		(rr_reg[1] ? 2'h3 : 2'h2);
	// ways 0 and 1 never chosen under half-lock, which acts at once
	assign a.way = a.half_lock ? half_way : full_way;
	assign all_valid = a.half_lock ? (&a.set_valid[3:2]) : (&a.set_valid);
	assign advance = a.take && all_valid;
	// modulo-4 step, or modulo-2 step of the high bit
	assign rr_next = a.half_lock ? (rr_reg + 2'h2) : (rr_reg + 2'h1);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rr_reg <= 2'h0;
		end else if (advance) begin
			rr_reg <= rr_next;
		end
	end
endmodule
`default_nettype wire

/* File: dv/fill_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fill_bus_model (
	input wire logic i_clk,
	input wire logic i_fill_req,
	input wire logic i_bus_write,
	output int o_reads,
	output int o_writes
);
	initial begin
		o_reads = 0;
		o_writes = 0;
	end
	// counts external bus reads and writes seen by the bus side
	always @(posedge i_clk) begin
		if (i_fill_req) o_reads <= o_reads + 1;
		if (i_bus_write) o_writes <= o_writes + 1;
	end
endmodule
`default_nettype wire

/* File: dv/instruction_cache_control_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "icache_ctl_cfg.svh"
module icc_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ctl_wr,
	input wire logic [31:0] i_ctl_wdata,
	input wire logic [31:0] o_ctl_rdata,
	input wire logic i_fetch_req,
	input wire logic i_region_hit,
	input wire logic o_stall,
	input wire logic o_fetch_done,
	input wire logic o_cache_hit,
	input wire logic o_fb_hit,
	input wire logic o_fill_req,
	input wire logic o_fill_burst,
	input wire logic o_fill_to_buffer,
	input wire icache_ctl_pkg::way_t o_fill_way,
	input wire logic i_store_req,
	input wire logic o_bus_write,
	input wire logic i_push_req,
	input wire logic o_push_done
);
	import icache_ctl_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence inv_wr;
		i_ctl_wr && i_ctl_wdata[8];
	endsequence
	sequence fetch_go;
		i_fetch_req && !o_stall;
	endsequence
	a_inv_starts_sweep: assert property (inv_wr |=> o_stall[*8])
		else $error("sweep not running");
	a_sweep_self_clear: assert property ($fell(o_stall) |-> !o_ctl_rdata[8])
		else $error("invalidate bit left set");
	a_sweep_blocks: assert property (o_stall && i_fetch_req |=> !o_fetch_done)
		else $error("fetch taken in sweep");
	a_fetch_answer: assert property (fetch_go |=>
		o_fetch_done && $onehot({o_cache_hit, o_fb_hit, o_fill_req}))
		else $error("bad fetch answer");
	a_hit_needs_en: assert property (o_cache_hit |-> $past(o_ctl_rdata[15]))
		else $error("hit while disabled");
	a_half_lock_ways: assert property (o_fill_req && o_fill_burst && !o_fill_to_buffer
		&& $past(o_ctl_rdata[11]) |-> o_fill_way[1])
		else $error("locked way allocated");
	a_default_mode: assert property (fetch_go and
		(!i_region_hit && o_ctl_rdata[15] && !o_ctl_rdata[10]) |=> !o_fb_hit && !o_fill_to_buffer)
		else $error("cacheable fetch buffered");
	a_store_to_bus: assert property (i_store_req && !o_stall |=> o_bus_write)
		else $error("store not on bus");
	a_push_answer: assert property (i_push_req && !o_stall |=> o_push_done)
		else $error("push not answered");
	a_ctl_masked: assert property (i_ctl_wr |=>
		o_ctl_rdata == ($past(i_ctl_wdata) & `CC_WRITE_MASK))
		else $error("register value wrong");
endmodule
bind instruction_cache_control icc_checker icc_checker_i (.*);
`default_nettype wire

/* File: dv/test_instruction_cache_control.sv */
`timescale 1ns/10ps
`default_nettype none
module test_instruction_cache_control;
	import icache_ctl_pkg::*;
	logic i_clk, i_rst, i_ctl_wr, i_fetch_req, i_region_hit, i_region_inhibit;
	logic i_store_req, i_push_req, o_fetch_done, o_cache_hit, o_fb_hit, o_fill_req;
	logic o_fill_burst, o_fill_to_buffer, o_bus_write, o_store_hit, o_push_done;
	logic o_push_valid, o_stall;
	logic [31:0] i_ctl_wdata, i_fetch_addr, i_store_addr, o_ctl_rdata, o_fill_addr;
	logic [31:0] o_push_addr;
	logic [1:0] i_transfer_type;
	set_idx_t i_push_set;
	way_t i_push_way, o_hit_way, o_fill_way, o_store_way;
	int reads, writes, error_cnt, num_checks, r0, w0;
	wire logic [7:0] fres = {o_fetch_done, o_cache_hit, o_fb_hit, o_fill_req,
		o_fill_burst, o_fill_to_buffer, o_cache_hit ? o_hit_way : o_fill_way};
	typedef struct {logic [31:0] wd; logic [31:0] ex;} row_t;
	row_t rows [4] = '{'{32'h0000_BC00, 32'h0000_BC00}, '{32'h0000_1400, 32'h0000_1400},
		'{32'h0000_2400, 32'h0000_2400}, '{32'h0000_0000, 32'h0000_0000}};
	instruction_cache_control instruction_cache_control_i (.*);
	fill_bus_model fill_bus_model_i (.i_clk, .i_fill_req(o_fill_req),
		.i_bus_write(o_bus_write), .o_reads(reads), .o_writes(writes));
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic tk;
		@(posedge i_clk);
		#1;
	endtask
	task automatic cw(input logic [31:0] d);
		tk;
		i_ctl_wr = 1;
		i_ctl_wdata = d;
		tk;
		i_ctl_wr = 0;
	endtask
	// one fetch; way bits compared only when kw is set
	task automatic fx(input logic [31:0] a, input logic [1:0] t, input logic h,
		input logic [7:0] e, input logic kw);
		tk;
		i_fetch_req = 1;
		i_fetch_addr = a;
		i_transfer_type = t;
		i_region_hit = h;
		tk;
		i_fetch_req = 0;
		chk(kw ? fres : {fres[7:2], 2'b00}, e);
	endtask
	task automatic pu(input way_t w, input logic v, input logic [31:0] a);
		tk;
		i_push_req = 1;
		i_push_set = 8'h05;
		i_push_way = w;
		tk;
		i_push_req = 0;
		chk({o_push_done, o_push_valid, o_push_addr}, {1'b1, v, a});
	endtask
	// one store; way bits compared only on a hit
	task automatic sx(input logic [31:0] a, input logic [3:0] e);
		tk;
		i_store_req = 1;
		i_store_addr = a;
		tk;
		i_store_req = 0;
		chk({o_bus_write, o_store_hit, o_store_hit ? o_store_way : 2'b00}, e);
	endtask
	initial begin
		int n;
		{i_ctl_wr, i_fetch_req, i_region_hit, i_region_inhibit, i_store_req} = '0;
		{i_push_req, i_transfer_type, i_ctl_wdata, i_fetch_addr, i_store_addr} = '0;
		{i_push_set, i_push_way} = '0;
		error_cnt = 0;
		num_checks = 0;
		i_rst = 1;
		repeat (2) @(posedge i_clk);
		#1 i_rst = 0;
		chk(o_ctl_rdata, 0);
		foreach (rows[k]) begin
			cw(rows[k].wd);
			chk(o_ctl_rdata, rows[k].ex);
		end
		cw(32'h0000_8100);
		chk(o_stall, 1);
		fx(0, 0, 0, 8'h00, 1);
		n = 2;
		while (o_stall && n < 400) begin
			tk;
			n++;
		end
		chk(n, 256);
		chk(o_ctl_rdata, 32'h0000_8000);
		for (int k = 1; k < 6; k++) begin
			fx({20'(k), 12'h054}, 0, 0, {6'b100110, 2'(k < 5 ? k - 1 : 0)}, 1);
			chk(o_fill_addr, {20'(k), 12'h050});
		end
		fx({20'h2, 12'h058}, 0, 0, 8'b1100_0001, 1);
		cw(32'h0000_8800);
		for (int k = 6; k < 9; k++)
			fx({20'(k), 12'h050}, 0, 0, {6'b100110, k == 7 ? 2'h3 : 2'h2}, 1);
		pu(0, 1, {20'h5, 12'h050});
		pu(0, 0, {20'h5, 12'h050});
		sx({20'h2, 12'h050}, 4'b1101);
		cw(32'h0000_9800);
		pu(3, 1, {20'h7, 12'h050});
		pu(3, 1, {20'h7, 12'h050});
		cw(32'h0000_A400);
		r0 = reads;
		w0 = writes;
		fx(32'h9000_0000, 0, 0, 8'b1001_1100, 0);
		fx(32'h9000_0004, 0, 0, 8'b1010_0000, 0);
		sx(32'h9000_0004, 4'b1000);
		fx(32'h9000_0008, 0, 0, 8'b1010_0000, 0);
		chk(reads, r0 + 1);
		chk(writes, w0 + 1);
		fx(32'h9000_000C, 1, 0, 8'b1001_0000, 0);
		fx(32'h9000_0010, 0, 1, 8'b1001_1000, 0);
		fx(32'h9000_0000, 0, 0, 8'b1001_1100, 0);
		cw(32'h0000_8400);
		fx(32'h9000_0000, 0, 0, 8'b1001_0000, 0);
		tk;
		i_rst = 1;
		tk;
		i_rst = 0;
		chk(o_ctl_rdata, 0);
		fx({20'h2, 12'h050}, 0, 0, 8'b1001_0000, 0);
		cw(32'h0000_8000);
		fx({20'h2, 12'h050}, 0, 0, 8'b1100_0001, 1);
		// region says inhibited although the default mode is cacheable
		i_region_inhibit = 1;
		fx({20'h2, 12'h050}, 0, 1, 8'b1001_0000, 0);
		summarize;
	end
endmodule
`default_nettype wire
